// ==== hw/rtcu_pkg.sv ====
package rtcu_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS        = 25;
   localparam int SECOND_NS            = 1000000000;
   localparam int SECOND_CYCLES        = SECOND_NS / CLK_PERIOD_NS;
   localparam int PRE_UPDATE_DELAY_NS  = 244000;
   // least time: round up to whole cycles
   localparam int PRE_UPDATE_CYCLES    = (PRE_UPDATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SECONDS   = 8'h00;
   localparam logic [7:0] ADDR_MINUTES   = 8'h04;
   localparam logic [7:0] ADDR_HOURS     = 8'h08;
   localparam logic [7:0] ADDR_ALM_SEC   = 8'h0c;
   localparam logic [7:0] ADDR_ALM_MIN   = 8'h10;
   localparam logic [7:0] ADDR_ALM_HOUR  = 8'h14;
   localparam logic [7:0] ADDR_CONTROL   = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h20;
   localparam logic [7:0] ADDR_IRQ_CLR   = 8'h24;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_FREEZE_BIT      = 0;
   localparam int CTRL_UIP_BIT         = 7;
   localparam int FLAG_PERIODIC_BIT    = 0;
   localparam int FLAG_ALARM_BIT       = 1;
   localparam int FLAG_UPDATE_BIT      = 2;
   localparam int FLAG_SUMMARY_BIT     = 7;
   localparam int FLAG_COUNT           = 3;
   localparam logic [1:0] DONT_CARE_CODE = 2'h3;
   localparam logic [7:0] SEC_LAST     = 8'h3b;
   localparam logic [7:0] MIN_LAST     = 8'h3b;
   localparam logic [7:0] HOUR_LAST    = 8'h17;
   localparam logic [7:0] BYTE_RESET   = 8'h00;
   localparam logic [2:0] FLAGS_RESET  = 3'h0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } rtcu_time_type;

   localparam rtcu_time_type TIME_RESET = '{hour: 8'h00, min: 8'h00, sec: 8'h00};

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PRE  = 2'b01,
      ST_DONE = 2'b10
   } rtcu_state_type;
endpackage : rtcu_pkg

// ==== hw/rtcu_time_inc.sv ====
`timescale 1ns/1ps
module rtcu_time_inc
(
   // time in and out
   input  rtcu_pkg::rtcu_time_type curTime,
   output rtcu_pkg::rtcu_time_type next_time
);
   // ----------------------------------------------------------------
   // binary seconds, minutes, hours with carry
   // ----------------------------------------------------------------
   always_comb
   begin
      next_time = curTime;
      if (curTime.sec >= rtcu_pkg::SEC_LAST)
      begin
         next_time.sec = 8'h00;
         if (curTime.min >= rtcu_pkg::MIN_LAST)
         begin
            next_time.min = 8'h00;
            if (curTime.hour >= rtcu_pkg::HOUR_LAST)
               next_time.hour = 8'h00;
            else
               next_time.hour = curTime.hour + 8'h01;
         end
         else
            next_time.min = curTime.min + 8'h01;
      end
      else
         next_time.sec = curTime.sec + 8'h01;
   end
endmodule : rtcu_time_inc

// ==== hw/rtcu_update_core.sv ====
// Operation
// - one update cycle every second, always
// - freeze holds user copy, internal keeps counting
// - alarm when all three bytes match/don't-care
// - update-ended flag each cycle, data stable
// - in-progress pulses; transfer one delay later
// - in-progress only between periodic flag settings
// - status read clears flags and summary
// - flags set regardless of enable bits
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module rtcu_update_core
#(
   parameter int SEC_CYCLES = rtcu_pkg::SECOND_CYCLES,
   parameter int PRE_CYCLES = rtcu_pkg::PRE_UPDATE_CYCLES
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // interrupt
   output logic             irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   rtcu_pkg::rtcu_time_type  userTime;
   rtcu_pkg::rtcu_time_type  coreTime;
   rtcu_pkg::rtcu_time_type  userAlarm;
   rtcu_pkg::rtcu_time_type  coreAlarm;
   rtcu_pkg::rtcu_time_type  incTime;
   rtcu_pkg::rtcu_time_type  next_userTime;
   rtcu_pkg::rtcu_time_type  next_userAlarm;
   rtcu_pkg::rtcu_state_type state;
   logic [31:0] secCnt;
   logic [31:0] preCnt;
   logic [31:0] uipAge;
   logic        freeze;
   logic        updateInProgress;
   logic [2:0]  flags;
   logic [2:0]  flagSnap;
   logic [2:0]  irqEn;
   logic [2:0]  flagSet;
   logic [2:0]  flagClr;
   logic        tick;
   logic        xferNow;
   logic        alarmHit;
   logic        setupPh;
   logic        wrEn;
   logic        rdEn;
   logic        wrTime;
   logic        wrAlarm;
   logic        wrCtrl;
   logic        unfreeze;
   logic        mapped;
   logic [31:0] rdMux;

   assign setupPh = psel && !penable;
   assign wrEn    = psel && penable && pready && pwrite;
   assign rdEn    = psel && penable && pready && !pwrite;
   assign wrTime  = wrEn && (paddr == rtcu_pkg::ADDR_SECONDS || paddr == rtcu_pkg::ADDR_MINUTES
                             || paddr == rtcu_pkg::ADDR_HOURS);
   assign wrAlarm = wrEn && (paddr == rtcu_pkg::ADDR_ALM_SEC || paddr == rtcu_pkg::ADDR_ALM_MIN
                             || paddr == rtcu_pkg::ADDR_ALM_HOUR);
   assign wrCtrl  = wrEn && paddr == rtcu_pkg::ADDR_CONTROL;
   assign unfreeze = wrCtrl && freeze && !pwdata[rtcu_pkg::CTRL_FREEZE_BIT];

   // ----------------------------------------------------------------
   // one-second timebase and update sequence
   // ----------------------------------------------------------------
   assign tick    = secCnt == 32'(SEC_CYCLES - 1);
   assign xferNow = state == rtcu_pkg::ST_PRE && preCnt == 32'(PRE_CYCLES - 1);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         secCnt <= 32'h0;
      else if (tick)
         secCnt <= 32'h0;
      else
         secCnt <= secCnt + 32'h1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state  <= rtcu_pkg::ST_IDLE;
         preCnt <= 32'h0;
      end
      else
      begin
         case (state)
            rtcu_pkg::ST_IDLE:
            begin
               preCnt <= 32'h0;
               if (tick)
                  state <= rtcu_pkg::ST_PRE;
            end
            rtcu_pkg::ST_PRE:
            begin
               preCnt <= preCnt + 32'h1;
               if (xferNow)
                  state <= rtcu_pkg::ST_DONE;
            end
            default:
               state <= rtcu_pkg::ST_IDLE;
         endcase
      end
   end

   // in-progress rises with the periodic flag and falls well before the next one
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         updateInProgress <= 1'b0;
      else if (tick)
         updateInProgress <= 1'b1;
      else if (state == rtcu_pkg::ST_DONE)
         updateInProgress <= 1'b0;
   end

   rtcu_time_inc u_inc
   (
      .curTime   (coreTime),
      .next_time (incTime)
   );

   // ----------------------------------------------------------------
   // double-buffered time and alarm
   // ----------------------------------------------------------------
   always_comb
   begin
      next_userTime  = userTime;
      next_userAlarm = userAlarm;
      if (paddr == rtcu_pkg::ADDR_SECONDS)
         next_userTime.sec = pwdata[7:0];
      else if (paddr == rtcu_pkg::ADDR_MINUTES)
         next_userTime.min = pwdata[7:0];
      else if (paddr == rtcu_pkg::ADDR_HOURS)
         next_userTime.hour = pwdata[7:0];
      if (paddr == rtcu_pkg::ADDR_ALM_SEC)
         next_userAlarm.sec = pwdata[7:0];
      else if (paddr == rtcu_pkg::ADDR_ALM_MIN)
         next_userAlarm.min = pwdata[7:0];
      else if (paddr == rtcu_pkg::ADDR_ALM_HOUR)
         next_userAlarm.hour = pwdata[7:0];
   end

   // unfreeze outranks a coinciding transfer: the host's set value wins, at the cost of one second
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         coreTime <= rtcu_pkg::TIME_RESET;
      else if (unfreeze)
         coreTime <= userTime;
      else if (xferNow)
         coreTime <= incTime;
      else if (wrTime && !freeze)
         coreTime <= next_userTime;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         userTime <= rtcu_pkg::TIME_RESET;
      else if (wrTime)
         userTime <= next_userTime;
      else if (xferNow && !freeze)
         userTime <= incTime;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         userAlarm <= rtcu_pkg::TIME_RESET;
         coreAlarm <= rtcu_pkg::TIME_RESET;
      end
      else
      begin
         if (wrAlarm)
            userAlarm <= next_userAlarm;
         if (unfreeze)
            coreAlarm <= userAlarm;
         else if (wrAlarm && !freeze)
            coreAlarm <= next_userAlarm;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         freeze <= 1'b0;
      else if (wrCtrl)
         freeze <= pwdata[rtcu_pkg::CTRL_FREEZE_BIT];
   end

   // compared against the freshly advanced internal time
   assign alarmHit = (coreAlarm.sec[7:6] == rtcu_pkg::DONT_CARE_CODE || coreAlarm.sec == coreTime.sec)
                  && (coreAlarm.min[7:6] == rtcu_pkg::DONT_CARE_CODE || coreAlarm.min == coreTime.min)
                  && (coreAlarm.hour[7:6] == rtcu_pkg::DONT_CARE_CODE || coreAlarm.hour == coreTime.hour);

   // ----------------------------------------------------------------
   // event flags and interrupt
   // ----------------------------------------------------------------
   always_comb
   begin
      flagSet = 3'h0;
      flagSet[rtcu_pkg::FLAG_PERIODIC_BIT] = tick;
      flagSet[rtcu_pkg::FLAG_ALARM_BIT]    = state == rtcu_pkg::ST_DONE && alarmHit;
      flagSet[rtcu_pkg::FLAG_UPDATE_BIT]   = state == rtcu_pkg::ST_DONE;
      flagClr = 3'h0;
      if (rdEn && paddr == rtcu_pkg::ADDR_IRQ_STAT)
         flagClr = flagSnap;
      else if (wrEn && paddr == rtcu_pkg::ADDR_IRQ_CLR)
         flagClr = pwdata[2:0];
   end

   // only bits already latched for the read are cleared; a new event wins over the clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         flags <= rtcu_pkg::FLAGS_RESET;
      else
         flags <= (flags & ~flagClr) | flagSet;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irqEn <= rtcu_pkg::FLAGS_RESET;
      else if (wrEn && paddr == rtcu_pkg::ADDR_IRQ_EN)
         irqEn <= pwdata[2:0];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(flags & irqEn);
   end

   // ----------------------------------------------------------------
   // apb slave: one wait state, data latched in setup
   // ----------------------------------------------------------------
   always_comb
   begin
      rdMux  = 32'h0;
      mapped = 1'b1;
      if (paddr == rtcu_pkg::ADDR_SECONDS)
         rdMux[7:0] = userTime.sec;
      else if (paddr == rtcu_pkg::ADDR_MINUTES)
         rdMux[7:0] = userTime.min;
      else if (paddr == rtcu_pkg::ADDR_HOURS)
         rdMux[7:0] = userTime.hour;
      else if (paddr == rtcu_pkg::ADDR_ALM_SEC)
         rdMux[7:0] = userAlarm.sec;
      else if (paddr == rtcu_pkg::ADDR_ALM_MIN)
         rdMux[7:0] = userAlarm.min;
      else if (paddr == rtcu_pkg::ADDR_ALM_HOUR)
         rdMux[7:0] = userAlarm.hour;
      else if (paddr == rtcu_pkg::ADDR_CONTROL)
      begin
         rdMux[rtcu_pkg::CTRL_FREEZE_BIT] = freeze;
         rdMux[rtcu_pkg::CTRL_UIP_BIT]    = updateInProgress;
      end
      else if (paddr == rtcu_pkg::ADDR_IRQ_STAT)
      begin
         rdMux[2:0] = flags;
         rdMux[rtcu_pkg::FLAG_SUMMARY_BIT] = |(flags & irqEn);
      end
      else if (paddr == rtcu_pkg::ADDR_IRQ_EN)
         rdMux[2:0] = irqEn;
      else if (paddr == rtcu_pkg::ADDR_IRQ_CLR)
         rdMux = 32'h0;
      else
         mapped = 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prdata   <= 32'h0;
         pslverr  <= 1'b0;
         flagSnap <= rtcu_pkg::FLAGS_RESET;
      end
      else if (setupPh)
      begin
         prdata   <= pwrite ? 32'h0 : rdMux;
         pslverr  <= !mapped;
         flagSnap <= flags;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pready <= 1'b0;
      else
         pready <= psel && penable && !pready;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         uipAge <= 32'h0;
      else if (!updateInProgress)
         uipAge <= 32'h0;
      else
         uipAge <= uipAge + 32'h1;
   end

   sequence s_transfer;
      xferNow ##1 state == rtcu_pkg::ST_DONE;
   endsequence

   property p_uip_rise;
      @(posedge clk) disable iff (rst) tick |=> updateInProgress && flags[rtcu_pkg::FLAG_PERIODIC_BIT];
   endproperty
   a_uip_rise: assert property (p_uip_rise) else $error("in-progress not raised on second");

   property p_xfer_delay;
      @(posedge clk) disable iff (rst) xferNow |-> uipAge == 32'(PRE_CYCLES - 1);
   endproperty
   a_xfer_delay: assert property (p_xfer_delay) else $error("transfer not one delay after rise");

   property p_freeze_hold;
      @(posedge clk) disable iff (rst) (freeze && !wrTime) |=> $stable(userTime);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("user time moved while frozen");

   property p_core_advance;
      @(posedge clk) disable iff (rst) (xferNow && !unfreeze) |=> coreTime != $past(coreTime);
   endproperty
   a_core_advance: assert property (p_core_advance) else $error("internal time did not advance");

   property p_alarm;
      @(posedge clk) disable iff (rst) (state == rtcu_pkg::ST_DONE && alarmHit)
         |=> flags[rtcu_pkg::FLAG_ALARM_BIT];
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm flag missed");

   property p_update_end;
      @(posedge clk) disable iff (rst) s_transfer |=> flags[rtcu_pkg::FLAG_UPDATE_BIT] && !updateInProgress
         ##1 (irq || !$past(irqEn[rtcu_pkg::FLAG_UPDATE_BIT]));
   endproperty
   a_update_end: assert property (p_update_end) else $error("update-ended not flagged");

   property p_read_clear;
      @(posedge clk) disable iff (rst) (rdEn && paddr == rtcu_pkg::ADDR_IRQ_STAT && flagSet == 3'h0)
         |=> (flags & $past(flagSnap)) == 3'h0;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("status read did not clear flags");

   property p_uip_low_stable;
      @(posedge clk) disable iff (rst) (!updateInProgress && !wrTime && !unfreeze) |=> $stable(coreTime);
   endproperty
   a_uip_low_stable: assert property (p_uip_low_stable) else $error("time changed with in-progress low");

   property p_uip_window;
      @(posedge clk) disable iff (rst) updateInProgress |-> uipAge < 32'(SEC_CYCLES - 1);
   endproperty
   a_uip_window: assert property (p_uip_window) else $error("in-progress spans periodic flags");

   property p_unfreeze;
      @(posedge clk) disable iff (rst) unfreeze |=> coreTime == $past(userTime);
   endproperty
   a_unfreeze: assert property (p_unfreeze) else $error("frozen writes not transferred");
endmodule : rtcu_update_core

// ==== verification/rtcu_host_model.sv ====
`timescale 1ns/1ps
module rtcu_host_model
#(
   parameter int RECOVER_CYCLES = 4
)
(
   // clock
   input  wire logic        clk,
   // apb master
   output logic      [7:0]  paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // ----------------------------------------------------------------
   // idle bus
   // ----------------------------------------------------------------
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // transfers
   // ----------------------------------------------------------------
   // chip stays unselected for a while after reset
   task automatic recover();
      repeat (RECOVER_CYCLES) @(posedge clk);
   endtask : recover

   // no own limit on the wait: only the bench watchdog cuts a hung slave
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       output logic [31:0] rdata, output logic err);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rdata   = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released lines show garbage, not the last value
      paddr   <= ~addr;
      pwdata  <= ~data;
   endtask : xfer
endmodule : rtcu_host_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   // short second keeps the run small; all timing derives from these
   localparam int SEC = 200;
   localparam int PRE = 20;
   logic        clk;
   logic        rst;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [31:0] cyc;
   logic [31:0] t1;
   logic [31:0] t2;
   logic [31:0] rdata;
   logic        err;
   logic [7:0]  curSec;
   logic [7:0]  nxt;
   logic [32:0] expQ[$];
   int          badCount;
   int          cmpCount;
   int          seed;

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
      cyc <= cyc + 32'h1;

   rtcu_update_core #(.SEC_CYCLES(SEC), .PRE_CYCLES(PRE)) u_rtcu_update_core
   (
      .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
   );

   rtcu_host_model u_rtcu_host_model
   (
      .clk(clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );

   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         badCount++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chkVal

   task automatic chkRead(input logic [32:0] got, input logic [32:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         badCount++;
         $display("MISMATCH at %0t: read %h expected %h", $time, got, exp);
      end
   endtask : chkRead

   task automatic printVerdict();
      $display("comparisons %0d, mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : printVerdict

   // read data is judged where the transfer completes
   always @(posedge clk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         if (expQ.size() == 0)
            chkRead({pslverr, prdata}, 33'h1_ffff_ffff);
         else
            chkRead({pslverr, prdata}, expQ.pop_front());
      end
   end

   // ----------------------------------------------------------------
   // stimulus helpers
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_rtcu_host_model.xfer(1'b1, a, d, rdata, err);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr = 1'b0);
      expQ.push_back({expErr, exp});
      u_rtcu_host_model.xfer(1'b0, a, 32'h0000_0000, rdata, err);
   endtask : rd

   // irq lags a status clear by a cycle, so let it settle first
   task automatic waitIrq(output logic [31:0] t);
      int n;
      n = 0;
      repeat (2) @(posedge clk);
      while (irq !== 1'b1 && n < 2 * SEC)
      begin
         n++;
         @(posedge clk);
      end
      if (irq !== 1'b1)
         chkVal({31'h0, irq}, 32'h1);
      t = cyc;
   endtask : waitIrq

   task automatic waitUntil(input logic [31:0] target);
      while (cyc < target)
         @(posedge clk);
   endtask : waitUntil

   function automatic logic [7:0] dontCare();
      return 8'hc0 | 8'($random(seed) & 32'h3f);
   endfunction : dontCare

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (30 * SEC) @(posedge clk);
      badCount++;
      printVerdict();
   end

   initial
   begin
      seed = 32'h9feb46b2;
      rst = 1'b1;
      cyc = 32'h0;
      badCount = 0;
      cmpCount = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      u_rtcu_host_model.recover();
      for (int a = 0; a <= 'h28; a += 4)
         rd(8'(a), 32'h0, a == 'h28);
      wr(rtcu_pkg::ADDR_IRQ_STAT, 32'h0000_00ff);
      wr(rtcu_pkg::ADDR_IRQ_EN, 32'h0000_0004);
      rd(rtcu_pkg::ADDR_IRQ_STAT, 32'h0);
      $display("test reset done");
      waitIrq(t1);
      rd(rtcu_pkg::ADDR_IRQ_STAT, 32'h85);
      rd(rtcu_pkg::ADDR_IRQ_STAT, 32'h0);
      repeat (2) @(posedge clk);
      chkVal({31'h0, irq}, 32'h0);
      rd(rtcu_pkg::ADDR_SECONDS, 32'h1);
      waitUntil(t1 + SEC - PRE - 12);
      rd(rtcu_pkg::ADDR_CONTROL, 32'h0);
      rd(rtcu_pkg::ADDR_SECONDS, 32'h1);
      waitUntil(t1 + SEC - PRE + 3);
      rd(rtcu_pkg::ADDR_CONTROL, 32'h80);
      waitIrq(t2);
      chkVal(t2 - t1, SEC);
      rd(rtcu_pkg::ADDR_IRQ_STAT, 32'h85);
      rd(rtcu_pkg::ADDR_SECONDS, 32'h2);
      waitUntil(t2 + SEC - PRE - 12);
      rd(rtcu_pkg::ADDR_SECONDS, 32'h2);
      $display("test update timing done");
      wr(rtcu_pkg::ADDR_CONTROL, 32'h1);
      wr(rtcu_pkg::ADDR_SECONDS, 32'h30);
      wr(rtcu_pkg::ADDR_MINUTES, 32'h05);
      wr(rtcu_pkg::ADDR_HOURS, 32'h02);
      rd(rtcu_pkg::ADDR_CONTROL, 32'h81);
      waitIrq(t1);
      rd(rtcu_pkg::ADDR_IRQ_STAT, 32'h85);
      rd(rtcu_pkg::ADDR_SECONDS, 32'h30);
      wr(rtcu_pkg::ADDR_CONTROL, 32'h0);
      waitIrq(t1);
      rd(rtcu_pkg::ADDR_IRQ_STAT, 32'h85);
      rd(rtcu_pkg::ADDR_SECONDS, 32'h31);
      rd(rtcu_pkg::ADDR_HOURS, 32'h02);
      $display("test freeze done");
      curSec = 8'h31;
      for (int i = 0; i < 3; i++)
      begin
         nxt = curSec + 8'h1;
         wr(rtcu_pkg::ADDR_ALM_SEC, {24'h0, (i == 0) ? dontCare() : nxt});
         wr(rtcu_pkg::ADDR_ALM_MIN, {24'h0, (i == 0) ? dontCare() : 8'h05});
         wr(rtcu_pkg::ADDR_ALM_HOUR, {24'h0, (i == 0) ? dontCare() : ((i == 1) ? 8'h02 : 8'h03)});
         waitIrq(t1);
         rd(rtcu_pkg::ADDR_IRQ_STAT, (i == 2) ? 32'h85 : 32'h87);
         curSec = nxt;
      end
      $display("test alarm done");
      wr(rtcu_pkg::ADDR_IRQ_EN, 32'h0);
      waitUntil(t1 + SEC + 10);
      chkVal({31'h0, irq}, 32'h0);
      rd(rtcu_pkg::ADDR_IRQ_STAT, 32'h05);
      waitUntil(t1 + 2 * SEC + 10);
      wr(rtcu_pkg::ADDR_IRQ_CLR, 32'h7);
      rd(rtcu_pkg::ADDR_IRQ_STAT, 32'h0);
      wr(rtcu_pkg::ADDR_IRQ_EN, 32'h1);
      waitIrq(t2);
      rd(rtcu_pkg::ADDR_CONTROL, 32'h80);
      rd(rtcu_pkg::ADDR_IRQ_STAT, 32'h81);
      // write outside the pre-update window while running: both copies take it
      waitUntil(t2 + PRE + 10);
      wr(rtcu_pkg::ADDR_SECONDS, 32'h10);
      waitUntil(t2 + SEC + 25);
      rd(rtcu_pkg::ADDR_SECONDS, 32'h11);
      $display("test interrupt mask done");
      repeat (4) @(posedge clk);
      printVerdict();
   end
endmodule : testbench
